// File: shared/sfwes_defines.svh
// constants of the serial flash write/erase sequencer
// assumes a 125 MHz reference clock and a 24-bit byte address
`ifndef SFWES_DEFINES_SVH
`define SFWES_DEFINES_SVH
`define SFWES_CMD_WR_ENABLE 8'h06
`define SFWES_CMD_WR_DISABLE 8'h04
`define SFWES_CMD_STAT_READ 8'h05
`define SFWES_CMD_STAT_WRITE 8'h01
`define SFWES_CMD_AUTO_PROG 8'hAD
`define SFWES_CMD_BUSY_ON 8'h70
`define SFWES_CMD_BUSY_OFF 8'h80
`define SFWES_CMD_ERASE_4K 8'h20
`define SFWES_CMD_ERASE_32K 8'h52
`define SFWES_CMD_ERASE_64K 8'hD8
`define SFWES_CMD_ERASE_ALL_A 8'h60
`define SFWES_CMD_ERASE_ALL_B 8'hC7
// frame lengths in whole bytes, opcode included
`define SFWES_LEN_SHORT 3'h1
`define SFWES_LEN_STWR 3'h2
`define SFWES_LEN_PROG_NEXT 3'h3
`define SFWES_LEN_ERASE 3'h4
`define SFWES_LEN_PROG_FIRST 3'h6
`define SFWES_LEN_MAX 3'h7
// status byte bit positions
`define SFWES_ST_BUSY 0
`define SFWES_ST_LATCH 1
`define SFWES_ST_AUTO 6
`define SFWES_MASK_WORD 24'h000001
`define SFWES_MASK_4K 24'h000FFF
`define SFWES_MASK_32K 24'h007FFF
`define SFWES_MASK_64K 24'h00FFFF
`define SFWES_MASK_ALL 24'hFFFFFF
`define SFWES_MEM_TOP 24'hFFFFFF
`define SFWES_WORD_STEP 24'h000002
// self-timed operation lengths in ns, and the reference period
`define SFWES_REF_PERIOD_NS 8
`define SFWES_PROG_NS 10000
`define SFWES_SECT_NS 25000000
`define SFWES_BLK_NS 25000000
`define SFWES_CHIP_NS 50000000
`endif

// File: shared/sfwes_pkg.sv
// types of the serial flash write/erase sequencer
// assumes sfwes_defines.svh for all numeric constants
package sfwes_pkg;
   typedef enum logic [2:0] {
      SFWES_OP_PROG,
      SFWES_OP_ERASE_4K,
      SFWES_OP_ERASE_32K,
      SFWES_OP_ERASE_64K,
      SFWES_OP_ERASE_ALL
   } sfwes_op_t;
   typedef struct packed {
      logic valid;
      sfwes_op_t op;
      logic [23:0] addr;
      logic [15:0] data;
   } sfwes_arr_req_t;
   // one received frame: byte count, opcode, following bytes oldest first
   typedef struct packed {
      logic [2:0] len;
      logic [7:0] cmd;
      logic [39:0] tail;
   } sfwes_frame_t;
   typedef enum logic [0:0] {
      SFWES_ST_IDLE,
      SFWES_ST_BUSY
   } sfwes_state_t;
endpackage

// File: logic/sfwes_sequencer.sv
// serial flash write/erase command sequencer
// assumes an spi host in mode 0 or 3 on spi_sck/spi_cs_n/spi_si and an array
// that takes one request per arr_req.valid pulse; array timing is internal.
// Notes on behaviour
// - word program into protected area ignored
// - auto mode accepts only program, status, disable
// - first word: opcode, address, even then odd
// - continuation: opcode plus two bytes, next addresses
// - word program starts at chip select rise
// - no wrap; top address ends auto mode
// - busy-on command enables busy on output
// - busy mode: select drives ready/busy level
// - deselect releases output in busy mode
// - busy-off command returns output to status
// - sector erase clears addressed 4 KByte
// - erase of protected region ignored
// - 32 KByte block erase, bits 15 up
// - 64 KByte block erase, upper bits
// - full erase ignored if any protection
// - erase self-timed from chip select rise
// - status readable except in busy mode, repeats until deselect
// - write enable sets latch at deselect
// - status write clears write latch
// - write disable clears bits, program continues
`timescale 1ns/10ps
`include "sfwes_defines.svh"
`default_nettype none
module sfwes_sequencer #(
   parameter int PROG_NS = `SFWES_PROG_NS,
   parameter int SECT_NS = `SFWES_SECT_NS,
   parameter int BLK_NS = `SFWES_BLK_NS,
   parameter int CHIP_NS = `SFWES_CHIP_NS
) (
   // system
   input wire logic ref_clk,
   input wire logic rst_n,
   // serial link
   input wire logic spi_sck,
   input wire logic spi_cs_n,
   input wire logic spi_si,
   output logic spi_so_o,
   output logic spi_so_oe,
   // protection setting
   input wire logic prot_en,
   input wire logic [23:0] prot_lo_addr,
   // array side and status
   output sfwes_pkg::sfwes_arr_req_t arr_req,
   output logic [7:0] status_o
);
   import sfwes_pkg::*;
   localparam int PROG_CYC = (PROG_NS + `SFWES_REF_PERIOD_NS - 1) / `SFWES_REF_PERIOD_NS;
   localparam int SECT_CYC = (SECT_NS + `SFWES_REF_PERIOD_NS - 1) / `SFWES_REF_PERIOD_NS;
   localparam int BLK_CYC = (BLK_NS + `SFWES_REF_PERIOD_NS - 1) / `SFWES_REF_PERIOD_NS;
   localparam int CHIP_CYC = (CHIP_NS + `SFWES_REF_PERIOD_NS - 1) / `SFWES_REF_PERIOD_NS;
   function automatic logic region_locked(input logic [23:0] base, input logic [23:0] mask,
                                          input logic en, input logic [23:0] lo);
      region_locked = en && ((base | mask) >= lo);
   endfunction

   // link side, clocked by the host's serial clock
   logic in_frame_ff, frame_tog_ff, byte_done, rd_act_ff;
   logic [2:0] bit_ff;
   logic [6:0] sh_ff;
   sfwes_frame_t frame_ff;
   logic [7:0] byte_in, stat_m_ff, stat_s_ff, out_sh_ff;
   // reference side
   logic cs_m_ff, cs_s_ff, cs_d_ff, tog_m_ff, tog_s_ff, tog_done_ff;
   logic exec, idle, wel_ff, auto_ff, hwb_ff, busy_drv_ff;
   sfwes_state_t state_ff;
   logic [31:0] timer_ff, iss_cyc, era_cyc;
   logic [23:0] ptr_ff, hi_free, iss_addr, word_addr, era_mask, era_addr;
   sfwes_arr_req_t arr_req_ff;
   logic [7:0] status_ff;
   logic iss, set_wel, clr_wel, set_auto, clr_auto, set_hwb, clr_hwb;
   sfwes_op_t iss_op, era_op;
   logic [15:0] iss_data;
   assign byte_in = {sh_ff, spi_si};
   assign byte_done = in_frame_ff && (bit_ff == 3'h7);

   // frame marker; cleared by deselect itself since no clock follows a frame
   always_ff @(posedge spi_sck or posedge spi_cs_n) begin
      if (spi_cs_n) begin
         in_frame_ff <= 1'b0;
      end else begin
         in_frame_ff <= 1'b1;
      end
   end

   always_ff @(posedge spi_sck or negedge rst_n) begin
      if (!rst_n) begin
         bit_ff <= 3'h0;
         sh_ff <= 7'h0;
         frame_tog_ff <= 1'b0;
      end else begin
         sh_ff <= byte_in[6:0];
         bit_ff <= in_frame_ff ? bit_ff + 3'h1 : 3'h1;
         if (!in_frame_ff) begin
            frame_tog_ff <= ~frame_tog_ff;
         end
      end
   end

   // frame contents stay frozen after deselect until the next frame's first clock
   always_ff @(posedge spi_sck or negedge rst_n) begin
      if (!rst_n) begin
         frame_ff <= '0;
      end else if (!in_frame_ff) begin
         frame_ff.len <= 3'h0;
      end else if (byte_done) begin
         if (frame_ff.len == 3'h0) begin
            frame_ff.cmd <= byte_in;
         end else begin
            frame_ff.tail <= {frame_ff.tail[31:0], byte_in};
         end
         if (frame_ff.len != `SFWES_LEN_MAX) begin
            frame_ff.len <= frame_ff.len + 3'h1;
         end
      end
   end

   // status into the link domain, bit by bit; a byte snapshot is taken per byte
   always_ff @(negedge spi_sck or negedge rst_n) begin
      if (!rst_n) begin
         stat_m_ff <= 8'h0;
         stat_s_ff <= 8'h0;
         out_sh_ff <= 8'h0;
      end else begin
         stat_m_ff <= status_ff;
         stat_s_ff <= stat_m_ff;
         if (bit_ff == 3'h0) begin
            out_sh_ff <= stat_s_ff;
         end else begin
            out_sh_ff <= {out_sh_ff[6:0], 1'b0};
         end
      end
   end

   always_ff @(negedge spi_sck or posedge spi_cs_n) begin
      if (spi_cs_n) begin
         rd_act_ff <= 1'b0;
      end else if (in_frame_ff && bit_ff == 3'h0 && frame_ff.len != 3'h0 &&
                   frame_ff.cmd == `SFWES_CMD_STAT_READ) begin
         rd_act_ff <= 1'b1;
      end
   end

   // pin drive mixes two domains on purpose: busy level needs no serial clock
   assign spi_so_oe = rd_act_ff | busy_drv_ff;
   assign spi_so_o = busy_drv_ff ? (state_ff == SFWES_ST_IDLE) : out_sh_ff[7];

   // chip select and frame toggle into the reference domain
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         cs_m_ff <= 1'b1;
         cs_s_ff <= 1'b1;
         cs_d_ff <= 1'b1;
         tog_m_ff <= 1'b0;
         tog_s_ff <= 1'b0;
         tog_done_ff <= 1'b0;
      end else begin
         cs_m_ff <= spi_cs_n;
         cs_s_ff <= cs_m_ff;
         cs_d_ff <= cs_s_ff;
         tog_m_ff <= frame_tog_ff;
         tog_s_ff <= tog_m_ff;
         if (cs_s_ff && !cs_d_ff) begin
            tog_done_ff <= tog_s_ff;
         end
      end
   end

   // a deselect with no clock in between must not replay the previous frame
   assign exec = cs_s_ff && !cs_d_ff && (tog_s_ff != tog_done_ff);
   assign idle = (state_ff == SFWES_ST_IDLE);
   assign hi_free = prot_en ? prot_lo_addr - 24'h1 : `SFWES_MEM_TOP;

   always_comb begin
      iss = 1'b0;
      iss_op = SFWES_OP_PROG;
      iss_addr = 24'h0;
      iss_data = 16'h0;
      iss_cyc = 32'h0;
      set_wel = 1'b0;
      clr_wel = 1'b0;
      set_auto = 1'b0;
      clr_auto = 1'b0;
      set_hwb = 1'b0;
      clr_hwb = 1'b0;
      word_addr = auto_ff ? ptr_ff : {frame_ff.tail[39:17], 1'b0};
      era_mask = `SFWES_MASK_4K;
      era_cyc = 32'(SECT_CYC);
      era_op = SFWES_OP_ERASE_4K;
      case (frame_ff.cmd)
         `SFWES_CMD_ERASE_32K: begin
            era_mask = `SFWES_MASK_32K;
            era_cyc = 32'(BLK_CYC);
            era_op = SFWES_OP_ERASE_32K;
         end
         `SFWES_CMD_ERASE_64K: begin
            era_mask = `SFWES_MASK_64K;
            era_cyc = 32'(BLK_CYC);
            era_op = SFWES_OP_ERASE_64K;
         end
         default: begin
         end
      endcase
      era_addr = frame_ff.tail[23:0] & ~era_mask;
      if (exec) begin
         case (frame_ff.cmd)
            `SFWES_CMD_WR_ENABLE: begin
               // in auto mode only program, status and disable are honoured
               if (frame_ff.len == `SFWES_LEN_SHORT && !auto_ff) begin
                  set_wel = 1'b1;
               end
            end
            `SFWES_CMD_WR_DISABLE: begin
               if (frame_ff.len == `SFWES_LEN_SHORT) begin
                  clr_wel = 1'b1;
                  clr_auto = 1'b1;
               end
            end
            `SFWES_CMD_STAT_WRITE: begin
               if (frame_ff.len == `SFWES_LEN_STWR && !auto_ff) begin
                  clr_wel = 1'b1;
               end
            end
            `SFWES_CMD_BUSY_ON: begin
               if (frame_ff.len == `SFWES_LEN_SHORT && !auto_ff) begin
                  set_hwb = 1'b1;
               end
            end
            `SFWES_CMD_BUSY_OFF: begin
               if (frame_ff.len == `SFWES_LEN_SHORT && !auto_ff) begin
                  clr_hwb = 1'b1;
               end
            end
            `SFWES_CMD_AUTO_PROG: begin
               if (wel_ff && idle &&
                   ((!auto_ff && frame_ff.len == `SFWES_LEN_PROG_FIRST &&
                     !region_locked(word_addr, `SFWES_MASK_WORD, prot_en, prot_lo_addr)) ||
                    (auto_ff && frame_ff.len == `SFWES_LEN_PROG_NEXT))) begin
                  iss = 1'b1;
                  iss_op = SFWES_OP_PROG;
                  iss_addr = word_addr;
                  iss_data = frame_ff.tail[15:0];
                  iss_cyc = 32'(PROG_CYC);
                  set_auto = 1'b1;
                  if ((word_addr | `SFWES_MASK_WORD) >= hi_free) begin
                     clr_auto = 1'b1;
                     clr_wel = 1'b1;
                  end
               end
            end
            `SFWES_CMD_ERASE_4K, `SFWES_CMD_ERASE_32K, `SFWES_CMD_ERASE_64K: begin
               if (wel_ff && idle && !auto_ff && frame_ff.len == `SFWES_LEN_ERASE &&
                   !region_locked(era_addr, era_mask, prot_en, prot_lo_addr)) begin
                  iss = 1'b1;
                  iss_op = era_op;
                  iss_addr = era_addr;
                  iss_cyc = era_cyc;
                  clr_wel = 1'b1;
               end
            end
            `SFWES_CMD_ERASE_ALL_A, `SFWES_CMD_ERASE_ALL_B: begin
               if (wel_ff && idle && !auto_ff && frame_ff.len == `SFWES_LEN_SHORT &&
                   !prot_en) begin
                  iss = 1'b1;
                  iss_op = SFWES_OP_ERASE_ALL;
                  iss_cyc = 32'(CHIP_CYC);
                  clr_wel = 1'b1;
               end
            end
            default: begin
            end
         endcase
      end
   end

   // write latch and auto mode; clearing wins so the top address exits cleanly
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         wel_ff <= 1'b0;
         auto_ff <= 1'b0;
         ptr_ff <= 24'h0;
      end else begin
         wel_ff <= clr_wel ? 1'b0 : (set_wel ? 1'b1 : wel_ff);
         auto_ff <= clr_auto ? 1'b0 : (set_auto ? 1'b1 : auto_ff);
         if (iss && iss_op == SFWES_OP_PROG) begin
            ptr_ff <= iss_addr + `SFWES_WORD_STEP;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         hwb_ff <= 1'b0;
         busy_drv_ff <= 1'b0;
      end else begin
         hwb_ff <= clr_hwb ? 1'b0 : (set_hwb ? 1'b1 : hwb_ff);
         // three reference cycles after select, so not literally instantaneous
         busy_drv_ff <= hwb_ff && auto_ff && !cs_s_ff;
      end
   end

   // self-timed operation; disable does not touch it
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         state_ff <= SFWES_ST_IDLE;
         timer_ff <= 32'h0;
      end else begin
         case (state_ff)
            SFWES_ST_IDLE: begin
               if (iss) begin
                  state_ff <= SFWES_ST_BUSY;
                  timer_ff <= iss_cyc;
               end
            end
            SFWES_ST_BUSY: begin
               if (timer_ff <= 32'h1) begin
                  state_ff <= SFWES_ST_IDLE;
               end else begin
                  timer_ff <= timer_ff - 32'h1;
               end
            end
            default: begin
               state_ff <= SFWES_ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         arr_req_ff <= '0;
         status_ff <= 8'h0;
      end else begin
         arr_req_ff.valid <= iss;
         if (iss) begin
            arr_req_ff.op <= iss_op;
            arr_req_ff.addr <= iss_addr;
            arr_req_ff.data <= iss_data;
         end
         status_ff <= 8'h0;
         status_ff[`SFWES_ST_BUSY] <= !idle;
         status_ff[`SFWES_ST_LATCH] <= wel_ff;
         status_ff[`SFWES_ST_AUTO] <= auto_ff;
      end
   end

   assign arr_req = arr_req_ff;
   assign status_o = status_ff;
   wr_en_latch_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      exec && frame_ff.cmd == `SFWES_CMD_WR_ENABLE && frame_ff.len == `SFWES_LEN_SHORT &&
      !auto_ff |=> wel_ff ##1 status_o[`SFWES_ST_LATCH]) else $error("write enable missed latch");
   wr_dis_keep_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      exec && frame_ff.cmd == `SFWES_CMD_WR_DISABLE && frame_ff.len == `SFWES_LEN_SHORT &&
      !idle && timer_ff > 32'h1 |=> !wel_ff && !auto_ff && !idle) else $error("write disable wrong");
   prot_prog_skip_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      exec && !auto_ff && frame_ff.cmd == `SFWES_CMD_AUTO_PROG &&
      region_locked(word_addr, `SFWES_MASK_WORD, prot_en, prot_lo_addr) |=> !arr_req_ff.valid)
      else $error("protected word programmed");
   auto_filter_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      exec && auto_ff && frame_ff.cmd != `SFWES_CMD_AUTO_PROG &&
      frame_ff.cmd != `SFWES_CMD_WR_DISABLE |=> !arr_req_ff.valid && $stable(wel_ff))
      else $error("command accepted in auto mode");
   req_at_rise_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      arr_req_ff.valid |-> $past(cs_s_ff && !cs_d_ff) && !status_o[`SFWES_ST_BUSY] ##1 !idle)
      else $error("request not tied to deselect");
   sect_align_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      arr_req_ff.valid && arr_req_ff.op == SFWES_OP_ERASE_4K |-> arr_req_ff.addr[11:0] == 12'h0)
      else $error("sector address not aligned");
   blk_align_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      arr_req_ff.valid && arr_req_ff.op == SFWES_OP_ERASE_32K |-> arr_req_ff.addr[14:0] == 15'h0)
      else $error("32k block not aligned");
   big_blk_align_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      arr_req_ff.valid && arr_req_ff.op == SFWES_OP_ERASE_64K |-> arr_req_ff.addr[15:0] == 16'h0)
      else $error("64k block not aligned");
   chip_prot_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      arr_req_ff.valid && arr_req_ff.op == SFWES_OP_ERASE_ALL |-> !$past(prot_en))
      else $error("full erase under protection");
   no_wrap_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      arr_req_ff.valid && arr_req_ff.op == SFWES_OP_PROG &&
      (arr_req_ff.addr | `SFWES_MASK_WORD) >= $past(hi_free) |-> !auto_ff && !wel_ff)
      else $error("auto mode kept at top address");
   busy_pin_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      busy_drv_ff |-> spi_so_oe && spi_so_o == idle) else $error("busy level wrong on output");
   busy_off_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      exec && frame_ff.cmd == `SFWES_CMD_BUSY_OFF && frame_ff.len == `SFWES_LEN_SHORT &&
      !auto_ff |=> !hwb_ff ##1 !busy_drv_ff) else $error("busy indication not disabled");
   so_release_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      cs_s_ff |=> !busy_drv_ff) else $error("output held after deselect");
endmodule
`default_nettype wire

// File: dv/sfwes_host.sv
// spi host model: drives select, clock and data in mode 0
// assumes the sequencer samples on clock rise and shifts out on fall
`timescale 1ns/10ps
`default_nettype none
module sfwes_host (
   // serial link
   output logic spi_sck,
   output logic spi_cs_n,
   output logic spi_si,
   input wire logic spi_so_o,
   input wire logic spi_so_oe
);
   logic [7:0] rx;
   initial begin
      spi_sck = 1'b0;
      spi_cs_n = 1'b1;
      spi_si = 1'b0;
      rx = 8'h00;
   end
   // tx is left aligned; clock stands still outside frames
   task automatic xfer(input logic [47:0] tx, input int n, input int rd);
      int i;
      spi_cs_n = 1'b0;
      for (i = 0; i < 8 * (n + rd); i++) begin
         if (i < 8 * n) spi_si = tx[47 - i];
         else spi_si = ~spi_si;
         #3 spi_sck = 1'b1;
         // a released output reads as the inverse so a late enable shows up
         if (i >= 8 * n) rx = {rx[6:0], spi_so_oe ? spi_so_o : ~spi_so_o};
         #3 spi_sck = 1'b0;
      end
      #3 spi_cs_n = 1'b1;
      // gap keeps select high well past the 3 cycle minimum
      #60;
   endtask
   task automatic sel(input logic v);
      spi_cs_n = v;
   endtask
endmodule
`default_nettype wire

// File: dv/testbench.sv
// self-checking bench for the write/erase sequencer
// assumes the host model in sfwes_host.sv and shortened op times
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import sfwes_pkg::*;
   typedef struct {
      logic [7:0] cmd;
      logic [23:0] adr;
      logic pe;
      logic [23:0] lo;
      logic hit;
      sfwes_op_t op;
      logic [23:0] ea;
   } sfwes_row_t;
   logic ref_clk, rst_n, spi_sck, spi_cs_n, spi_si, spi_so_o, spi_so_oe, prot_en;
   logic [23:0] prot_lo_addr;
   sfwes_arr_req_t arr_req, req_q;
   logic [7:0] status_o;
   int err_total = 0, samples_checked = 0, req_cnt = 0, cyc = 0, n0, i;
   sfwes_row_t rows [8] = '{
      '{8'h20, 24'h123456, 1'b0, 24'h0, 1'b1, SFWES_OP_ERASE_4K, 24'h123000},
      '{8'h52, 24'h12FFFF, 1'b0, 24'h0, 1'b1, SFWES_OP_ERASE_32K, 24'h128000},
      '{8'hD8, 24'h12FFFF, 1'b0, 24'h0, 1'b1, SFWES_OP_ERASE_64K, 24'h120000},
      '{8'h60, 24'h0, 1'b0, 24'h0, 1'b1, SFWES_OP_ERASE_ALL, 24'h0},
      '{8'hC7, 24'h0, 1'b0, 24'h0, 1'b1, SFWES_OP_ERASE_ALL, 24'h0},
      '{8'h20, 24'h7FFABC, 1'b1, 24'h800000, 1'b1, SFWES_OP_ERASE_4K, 24'h7FF000},
      '{8'h52, 24'h900000, 1'b1, 24'h800000, 1'b0, SFWES_OP_ERASE_32K, 24'h0},
      '{8'h60, 24'h0, 1'b1, 24'h800000, 1'b0, SFWES_OP_ERASE_ALL, 24'h0}};
   // program time stretched so the busy window outlasts the select lag
   localparam int PROG_SIM_NS = 160;
   localparam int ERASE_SIM_NS = 400;
   sfwes_sequencer #(.PROG_NS(PROG_SIM_NS), .SECT_NS(ERASE_SIM_NS), .BLK_NS(ERASE_SIM_NS),
      .CHIP_NS(ERASE_SIM_NS)) dut_u (
      .ref_clk(ref_clk), .rst_n(rst_n), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n),
      .spi_si(spi_si), .spi_so_o(spi_so_o), .spi_so_oe(spi_so_oe), .prot_en(prot_en),
      .prot_lo_addr(prot_lo_addr), .arr_req(arr_req), .status_o(status_o));
   sfwes_host host_u (.spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_si(spi_si),
      .spi_so_o(spi_so_o), .spi_so_oe(spi_so_oe));
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   task automatic stop_test;
      $display("checks %0d errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: seen %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cyc_n(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   // bounded wait for the busy bit to drop
   task automatic idle;
      int k;
      for (k = 0; k < 300 && status_o[0] !== 1'b0; k++) @(negedge ref_clk);
      if (k == 300) err_total++;
   endtask
   task automatic cmd1(input logic [7:0] c);
      host_u.xfer({c, 40'h0}, 1, 0);
   endtask
   // capture each array request and bound the run
   always @(posedge ref_clk) begin
      if (arr_req.valid === 1'b1) begin
         req_q <= arr_req;
         req_cnt <= req_cnt + 1;
      end
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total++;
         stop_test();
      end
   end
   initial begin
      rst_n = 1'b0;
      prot_en = 1'b0;
      prot_lo_addr = 24'h000001;
      cyc_n(3);
      rst_n = 1'b1;
      cyc_n(2);
      chk(status_o, 8'h00);
      chk(spi_so_oe, 1'b0);
      for (i = 0; i < 8; i++) begin
         @(negedge ref_clk);
         prot_en = rows[i].pe;
         prot_lo_addr = rows[i].lo;
         n0 = req_cnt;
         cmd1(8'h06);
         host_u.xfer({8'h05, 40'h0}, 1, 1);
         chk(host_u.rx, 8'h02);
         host_u.xfer({rows[i].cmd, rows[i].adr, 16'h0}, rows[i].op == SFWES_OP_ERASE_ALL ? 1 : 4, 0);
         // second repeated byte is read while the erase still runs
         host_u.xfer({8'h05, 40'h0}, 1, 2);
         chk(host_u.rx, rows[i].hit ? 8'h01 : 8'h02);
         chk(req_cnt - n0, rows[i].hit);
         if (rows[i].hit) begin
            chk(req_q.op, rows[i].op);
            if (rows[i].op != SFWES_OP_ERASE_ALL) chk(req_q.addr, rows[i].ea);
         end
         // disable during the erase clears the latch and leaves the erase running
         cmd1(8'h04);
         chk(status_o, rows[i].hit ? 8'h01 : 8'h00);
         idle();
      end
      @(negedge ref_clk);
      prot_en = 1'b0;
      n0 = req_cnt;
      // array is fully erased by the rows above
      cmd1(8'h06);
      cmd1(8'h70);
      host_u.xfer({8'hAD, 24'h000101, 16'hA55A}, 6, 0);
      chk(req_q.op, SFWES_OP_PROG);
      chk(req_q.addr, 24'h000100);
      chk(req_q.data, 16'hA55A);
      host_u.sel(1'b0);
      cyc_n(4);
      chk({spi_so_oe, spi_so_o}, 2'b10);
      idle();
      cyc_n(4);
      chk({spi_so_oe, spi_so_o}, 2'b11);
      host_u.sel(1'b1);
      cyc_n(4);
      chk(spi_so_oe, 1'b0);
      chk(status_o, 8'h42);
      cyc_n(4);
      host_u.xfer({8'hAD, 16'h1234, 24'h0}, 3, 0);
      chk(req_q.addr, 24'h000102);
      chk(req_q.data, 16'h1234);
      idle();
      host_u.xfer({8'h20, 40'h0}, 4, 0);
      chk(req_cnt - n0, 2);
      cmd1(8'h04);
      chk(status_o, 8'h00);
      host_u.xfer({8'hAD, 16'h5555, 24'h0}, 3, 0);
      chk(req_cnt - n0, 2);
      // busy indication switched off before the next program
      cmd1(8'h80);
      cmd1(8'h06);
      host_u.xfer({8'hAD, 24'h000200, 16'h0F0F}, 6, 0);
      host_u.sel(1'b0);
      cyc_n(4);
      chk(spi_so_oe, 1'b0);
      host_u.sel(1'b1);
      idle();
      cmd1(8'h04);
      cyc_n(2);
      prot_en = 1'b1;
      prot_lo_addr = 24'h000100;
      n0 = req_cnt;
      cmd1(8'h06);
      host_u.xfer({8'hAD, 24'h000300, 16'h1111}, 6, 0);
      chk(req_cnt - n0, 0);
      host_u.xfer({8'hAD, 24'h0000FE, 16'h2222}, 6, 0);
      chk(req_q.addr, 24'h0000FE);
      idle();
      chk(status_o, 8'h00);
      cmd1(8'h06);
      host_u.xfer({8'h01, 40'h0}, 2, 0);
      chk(status_o, 8'h00);
      // reset in mid-run drops the latch; the first frame after it still executes
      cmd1(8'h06);
      chk(status_o, 8'h02);
      @(negedge ref_clk);
      rst_n = 1'b0;
      cyc_n(3);
      chk(status_o, 8'h00);
      rst_n = 1'b1;
      cyc_n(2);
      chk({arr_req.valid, status_o}, 9'h000);
      cmd1(8'h06);
      chk(status_o, 8'h02);
      stop_test();
   end
endmodule
`default_nettype wire
